// *** hw/fcl_dev.sv ***
// coprocessor end of the host link: request parser and responder
// Function
// - host closes each request with semicolon
// - every reply ends in dot or bang
// - dot acknowledges success and closes indications
// - bang reports last request failed
// - function code selects request type
// - all exchanged values are unsigned bytes
// - true is ffh, false is 00h
// - process array holds at most 255 bytes
// - offset 0..254 plus length, 255 invalid
// - multi-byte values little endian, low first
// - each request gets one reply, dot on success or bang on failure
// - status bits 1:0 give coprocessor state
// - status bits 4:2 give array size
// - init carries bit rate and node number
// - array read returns count actually copied
`include "fcl_map.svh"
module fcl_dev (
  input wire logic clk,
  input wire logic sys_rst,
  fcl_if.dev lnk,
  input wire logic engine_ready,
  input wire logic ind_valid,
  input wire logic [7:0] ind_code,
  output logic ind_taken,
  output logic init_pulse,
  output logic [7:0] bps_sel,
  output logic [7:0] node_num,
  output logic [1:0] dev_state,
  input wire logic eng_we,
  input wire logic [7:0] eng_addr,
  input wire logic [7:0] eng_wdata,
  output logic [7:0] eng_rdata
);
  fcl_pkg::fcl_dev_state_e state_reg, state_next;
  logic [7:0] code_reg, code_next;
  logic [7:0] a0_reg, a0_next;
  logic argi_reg, argi_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] left_reg, left_next;
  logic [7:0] rc_reg, rc_next;
  logic ok_reg, ok_next;
  logic [1:0] mode_reg, mode_next;
  logic [7:0] bps_reg, bps_next;
  logic [7:0] node_reg, node_next;
  logic init_reg, init_next;
  logic txv_reg, txv_next;
  logic [7:0] txd_reg, txd_next;
  logic rxr_reg, rxr_next;
  logic indt_reg, indt_next;
  logic rx_fire;
  logic can_load;
  logic img_we;
  logic [7:0] img_rdata;
  logic [7:0] avail;
  logic [7:0] clip;
  logic [7:0] status_byte;

  fcl_img u_img (
    .clk(clk),
    .lnk_we(img_we),
    .lnk_addr(ptr_reg),
    .lnk_wdata(lnk.h2d_data),
    .lnk_rdata(img_rdata),
    .eng_we(eng_we),
    .eng_addr(eng_addr),
    .eng_wdata(eng_wdata),
    .eng_rdata(eng_rdata)
  );

  assign rx_fire = lnk.h2d_valid && rxr_reg;
  assign can_load = !txv_reg || lnk.d2h_ready;
  // bytes left from an offset to the array end; invalid offset gives none
  assign avail = (a0_reg >= `FCL_IMG_LEN) ? 8'h00 : `FCL_IMG_LEN - a0_reg;
  assign clip = (lnk.h2d_data < avail) ? lnk.h2d_data : avail;
  assign status_byte = {3'h0, `FCL_SIZE_CODE, mode_reg};
  // only the first rc bytes land; the rest of the payload is absorbed
  assign img_we = (state_reg == fcl_pkg::DS_RX_DATA) && rx_fire
    && ((ptr_reg - a0_reg) < rc_reg);

  always_comb
  begin
    state_next = state_reg;
    code_next = code_reg;
    a0_next = a0_reg;
    argi_next = argi_reg;
    ptr_next = ptr_reg;
    left_next = left_reg;
    rc_next = rc_reg;
    ok_next = ok_reg;
    mode_next = mode_reg;
    bps_next = bps_reg;
    node_next = node_reg;
    init_next = 1'b0;
    txv_next = txv_reg && !lnk.d2h_ready;
    txd_next = txd_reg;
    indt_next = 1'b0;
    if (mode_reg == `FCL_ST_BOOT && engine_ready)
      mode_next = `FCL_ST_READY;
    case (state_reg)
      fcl_pkg::DS_RX_CODE:
      begin
        if (rx_fire)
        begin
          code_next = lnk.h2d_data;
          argi_next = 1'b0;
          ok_next = 1'b0;
          case (lnk.h2d_data)
            `FCL_FC_ID, `FCL_FC_STATUS: state_next = fcl_pkg::DS_RX_TERM;
            `FCL_FC_INIT, `FCL_FC_READ, `FCL_FC_WRITE: state_next = fcl_pkg::DS_RX_ARG;
            `FCL_TERM_REQ: state_next = fcl_pkg::DS_TX_END;
            default: state_next = fcl_pkg::DS_DISCARD;
          endcase
        end
        else if (ind_valid)
        begin
          // indications only start between requests
          indt_next = 1'b1;
          txd_next = ind_code;
          state_next = fcl_pkg::DS_IND;
        end
      end
      fcl_pkg::DS_RX_ARG:
      begin
        if (rx_fire)
        begin
          argi_next = 1'b1;
          if (!argi_reg)
            a0_next = lnk.h2d_data;
          else
          begin
            // second argument: data byte count for read and write, node for init
            left_next = lnk.h2d_data;
            rc_next = clip;
            ptr_next = a0_reg;
            if (code_reg == `FCL_FC_WRITE && lnk.h2d_data != 8'h00)
              state_next = fcl_pkg::DS_RX_DATA;
            else
              state_next = fcl_pkg::DS_RX_TERM;
          end
        end
      end
      fcl_pkg::DS_RX_DATA:
      begin
        // counted by length, so payload bytes equal to the terminator are safe
        if (rx_fire)
        begin
          ptr_next = ptr_reg + 8'h01;
          left_next = left_reg - 8'h01;
          if (left_reg == 8'h01)
            state_next = fcl_pkg::DS_RX_TERM;
        end
      end
      fcl_pkg::DS_RX_TERM:
      begin
        if (rx_fire)
        begin
          if (lnk.h2d_data != `FCL_TERM_REQ)
            state_next = fcl_pkg::DS_DISCARD;
          else
          begin
            ok_next = 1'b1;
            ptr_next = a0_reg;
            state_next = fcl_pkg::DS_TX_HEAD;
            case (code_reg)
              `FCL_FC_INIT:
              begin
                ok_next = (mode_reg != `FCL_ST_BOOT) && (a0_reg <= `FCL_BPS_MAX)
                  && (left_reg <= `FCL_NODE_MAX);
                if ((mode_reg != `FCL_ST_BOOT) && (a0_reg <= `FCL_BPS_MAX)
                  && (left_reg <= `FCL_NODE_MAX))
                begin
                  bps_next = a0_reg;
                  node_next = left_reg;
                  init_next = 1'b1;
                  mode_next = `FCL_ST_RUN;
                end
                state_next = fcl_pkg::DS_TX_END;
              end
              `FCL_FC_READ, `FCL_FC_WRITE: ok_next = (rc_reg != 8'h00);
              `FCL_FC_ID: ptr_next = 8'h00;
              default: ok_next = 1'b1;
            endcase
          end
        end
      end
      fcl_pkg::DS_DISCARD:
      begin
        if (rx_fire && lnk.h2d_data == `FCL_TERM_REQ)
        begin
          ok_next = 1'b0;
          state_next = fcl_pkg::DS_TX_END;
        end
      end
      fcl_pkg::DS_TX_HEAD:
      begin
        if (can_load)
        begin
          txv_next = 1'b1;
          state_next = fcl_pkg::DS_TX_END;
          case (code_reg)
            `FCL_FC_STATUS: txd_next = status_byte;
            `FCL_FC_ID:
            begin
              txd_next = `FCL_ID_B0;
              ptr_next = 8'h01;
              state_next = fcl_pkg::DS_TX_DATA;
            end
            default:
            begin
              txd_next = rc_reg;
              left_next = rc_reg;
              if (code_reg == `FCL_FC_READ && rc_reg != 8'h00)
                state_next = fcl_pkg::DS_TX_DATA;
            end
          endcase
        end
      end
      fcl_pkg::DS_TX_DATA:
      begin
        if (can_load)
        begin
          txv_next = 1'b1;
          ptr_next = ptr_reg + 8'h01;
          if (code_reg == `FCL_FC_ID)
          begin
            case (ptr_reg[1:0])
              2'h1: txd_next = `FCL_ID_B1;
              2'h2: txd_next = `FCL_ID_B2;
              default: txd_next = `FCL_ID_B3;
            endcase
            if (ptr_reg[1:0] == 2'h3)
              state_next = fcl_pkg::DS_TX_END;
          end
          else
          begin
            txd_next = img_rdata;
            left_next = left_reg - 8'h01;
            if (left_reg == 8'h01)
              state_next = fcl_pkg::DS_TX_END;
          end
        end
      end
      fcl_pkg::DS_TX_END, fcl_pkg::DS_IND:
      begin
        if (can_load && state_reg == fcl_pkg::DS_IND)
        begin
          txv_next = 1'b1;
          ok_next = 1'b1;
          state_next = fcl_pkg::DS_TX_END;
        end
        else if (can_load)
        begin
          txv_next = 1'b1;
          txd_next = ok_reg ? `FCL_TERM_ACK : `FCL_TERM_NAK;
          state_next = fcl_pkg::DS_RX_CODE;
        end
      end
      default: state_next = fcl_pkg::DS_RX_CODE;
    endcase
    // receive only while parsing, so a new request waits for the terminator
    rxr_next = (state_next == fcl_pkg::DS_RX_CODE && !(state_reg == fcl_pkg::DS_RX_CODE
      && !rx_fire && ind_valid)) || state_next == fcl_pkg::DS_RX_ARG
      || state_next == fcl_pkg::DS_RX_DATA || state_next == fcl_pkg::DS_RX_TERM
      || state_next == fcl_pkg::DS_DISCARD;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= fcl_pkg::DS_RX_CODE;
      code_reg <= 8'h00;
      a0_reg <= 8'h00;
      argi_reg <= 1'b0;
      ptr_reg <= 8'h00;
      left_reg <= 8'h00;
      rc_reg <= 8'h00;
      ok_reg <= 1'b0;
      mode_reg <= `FCL_ST_BOOT;
      bps_reg <= 8'h00;
      node_reg <= 8'h00;
      init_reg <= 1'b0;
      txv_reg <= 1'b0;
      txd_reg <= 8'h00;
      rxr_reg <= 1'b0;
      indt_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      code_reg <= code_next;
      a0_reg <= a0_next;
      argi_reg <= argi_next;
      ptr_reg <= ptr_next;
      left_reg <= left_next;
      rc_reg <= rc_next;
      ok_reg <= ok_next;
      mode_reg <= mode_next;
      bps_reg <= bps_next;
      node_reg <= node_next;
      init_reg <= init_next;
      txv_reg <= txv_next;
      txd_reg <= txd_next;
      rxr_reg <= rxr_next;
      indt_reg <= indt_next;
    end
  end

  assign lnk.h2d_ready = rxr_reg;
  assign lnk.d2h_valid = txv_reg;
  assign lnk.d2h_data = txd_reg;
  assign ind_taken = indt_reg;
  assign init_pulse = init_reg;
  assign bps_sel = bps_reg;
  assign node_num = node_reg;
  assign dev_state = mode_reg;
endmodule // fcl_dev

// *** pkg/fcl_map.svh ***
// constants of the host link: codes, terminators, status fields, limits
`ifndef FCL_MAP_SVH
`define FCL_MAP_SVH
`define FCL_TERM_REQ 8'h3b
`define FCL_TERM_ACK 8'h2e
`define FCL_TERM_NAK 8'h21
`define FCL_TRUE 8'hff
`define FCL_FALSE 8'h00
`define FCL_FC_ID 8'h56
`define FCL_FC_STATUS 8'h53
`define FCL_FC_INIT 8'h49
`define FCL_FC_READ 8'h52
`define FCL_FC_WRITE 8'h57
`define FCL_IMG_LEN 8'hff
`define FCL_OFS_INVALID 8'hff
`define FCL_BPS_MAX 8'h08
`define FCL_NODE_MAX 8'h7f
`define FCL_SIZE_CODE 3'h7
`define FCL_ST_BOOT 2'h0
`define FCL_ST_READY 2'h1
`define FCL_ST_RUN 2'h2
`define FCL_ST_LSB 0
`define FCL_SIZE_LSB 2
// identification bytes: values are arbitrary
`define FCL_ID_B0 8'h5a
`define FCL_ID_B1 8'h0c
`define FCL_ID_B2 8'h01
`define FCL_ID_B3 8'h02
`endif

// *** pkg/fcl_pkg.sv ***
// types shared by both ends of the host link
package fcl_pkg;
  typedef logic [7:0] fcl_byte_t;
  typedef enum logic [3:0] {
    DS_RX_CODE, DS_RX_ARG, DS_RX_DATA, DS_RX_TERM, DS_DISCARD,
    DS_TX_HEAD, DS_TX_DATA, DS_TX_END, DS_IND
  } fcl_dev_state_e;
  typedef enum logic [2:0] {
    HS_IDLE, HS_CODE, HS_ARG, HS_PAY, HS_TERM, HS_WAIT
  } fcl_host_state_e;
endpackage

// *** pkg/fcl_if.sv ***
// byte channel between host and coprocessor, one stream each way
interface fcl_if;
  logic [7:0] h2d_data;
  logic h2d_valid;
  logic h2d_ready;
  logic [7:0] d2h_data;
  logic d2h_valid;
  logic d2h_ready;
  modport dev (input h2d_data, input h2d_valid, output h2d_ready,
    output d2h_data, output d2h_valid, input d2h_ready);
  modport host (output h2d_data, output h2d_valid, input h2d_ready,
    input d2h_data, input d2h_valid, output d2h_ready);
endinterface

// *** hw/fcl_img.sv ***
// process image: byte array with a link port and an engine port
`include "fcl_map.svh"
module fcl_img (
  input wire logic clk,
  input wire logic lnk_we,
  input wire logic [7:0] lnk_addr,
  input wire logic [7:0] lnk_wdata,
  output logic [7:0] lnk_rdata,
  input wire logic eng_we,
  input wire logic [7:0] eng_addr,
  input wire logic [7:0] eng_wdata,
  output logic [7:0] eng_rdata
);
  // offset 255 is the invalid marker, so only 0..254 exist
  logic [7:0] mem [0:254];

  always_ff @(posedge clk)
  begin
    if (eng_we && eng_addr != `FCL_OFS_INVALID)
      mem[eng_addr] <= eng_wdata;
    // link write comes last so it wins a same-address clash
    if (lnk_we && lnk_addr != `FCL_OFS_INVALID)
      mem[lnk_addr] <= lnk_wdata;
    // engine port leaves the block, so its read is registered
    eng_rdata <= (eng_addr == `FCL_OFS_INVALID) ? 8'h00 : mem[eng_addr];
  end

  always_comb
  begin
    lnk_rdata = (lnk_addr == `FCL_OFS_INVALID) ? 8'h00 : mem[lnk_addr];
  end
endmodule // fcl_img

// *** hw/fcl_host.sv ***
// host end of the link: sends requests and splits replies into bytes
`include "fcl_map.svh"
module fcl_host (
  input wire logic clk,
  input wire logic sys_rst,
  fcl_if.host lnk,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [1:0] cmd_nargs,
  input wire logic [7:0] cmd_arg0,
  input wire logic [7:0] cmd_arg1,
  output logic cmd_ready,
  input wire logic pay_valid,
  input wire logic [7:0] pay_data,
  output logic pay_take,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_end,
  output logic [7:0] rsp_result
);
  fcl_pkg::fcl_host_state_e state_reg, state_next;
  logic [7:0] code_reg, code_next;
  logic [1:0] nargs_reg, nargs_next;
  logic [7:0] a0_reg, a0_next;
  logic [7:0] a1_reg, a1_next;
  logic [7:0] left_reg, left_next;
  logic first_reg, first_next;
  logic txv_reg, txv_next;
  logic [7:0] txd_reg, txd_next;
  logic take_reg, take_next;
  logic rdy_reg, rdy_next;
  logic rv_reg, rv_next;
  logic [7:0] rd_reg, rd_next;
  logic re_reg, re_next;
  logic [7:0] res_reg, res_next;
  logic can_load;
  logic rx_fire;
  logic is_term;

  assign can_load = !txv_reg || lnk.h2d_ready;
  assign rx_fire = lnk.d2h_valid;
  // reply length is known from the request code and, for an array read, its count byte, so data bytes never end a frame
  assign is_term = (left_reg == 8'h00) && !first_reg;

  always_comb
  begin
    state_next = state_reg;
    code_next = code_reg;
    nargs_next = nargs_reg;
    a0_next = a0_reg;
    a1_next = a1_reg;
    left_next = left_reg;
    first_next = first_reg;
    txv_next = txv_reg && !lnk.h2d_ready;
    txd_next = txd_reg;
    take_next = 1'b0;
    rv_next = 1'b0;
    rd_next = rd_reg;
    re_next = 1'b0;
    res_next = res_reg;
    case (state_reg)
      fcl_pkg::HS_IDLE:
        if (cmd_valid)
        begin
          code_next = cmd_code;
          nargs_next = cmd_nargs;
          a0_next = cmd_arg0;
          a1_next = cmd_arg1;
          state_next = fcl_pkg::HS_CODE;
        end
      fcl_pkg::HS_CODE:
        if (can_load)
        begin
          txv_next = 1'b1;
          txd_next = code_reg;
          state_next = (nargs_reg == 2'h0) ? fcl_pkg::HS_TERM : fcl_pkg::HS_ARG;
        end
      fcl_pkg::HS_ARG:
        if (can_load)
        begin
          txv_next = 1'b1;
          txd_next = a0_reg;
          a0_next = a1_reg;
          nargs_next = nargs_reg - 2'h1;
          if (nargs_reg == 2'h1)
            state_next = (code_reg == `FCL_FC_WRITE && a1_reg != 8'h00)
              ? fcl_pkg::HS_PAY : fcl_pkg::HS_TERM;
          left_next = a1_reg;
        end
      fcl_pkg::HS_PAY:
        if (can_load && pay_valid && !take_reg)
        begin
          txv_next = 1'b1;
          txd_next = pay_data;
          take_next = 1'b1;
          left_next = left_reg - 8'h01;
          if (left_reg == 8'h01)
            state_next = fcl_pkg::HS_TERM;
        end
      fcl_pkg::HS_TERM:
        if (can_load)
        begin
          txv_next = 1'b1;
          txd_next = `FCL_TERM_REQ;
          first_next = (code_reg == `FCL_FC_READ);
          case (code_reg)
            `FCL_FC_ID: left_next = 8'h04;
            `FCL_FC_INIT: left_next = 8'h00;
            `FCL_FC_STATUS, `FCL_FC_READ, `FCL_FC_WRITE: left_next = 8'h01;
            default: left_next = 8'h00;
          endcase
          state_next = fcl_pkg::HS_WAIT;
        end
      fcl_pkg::HS_WAIT:
        if (rx_fire)
        begin
          rv_next = 1'b1;
          rd_next = lnk.d2h_data;
          if (first_reg)
          begin
            // leading count byte of an array read sizes the rest
            first_next = 1'b0;
            left_next = lnk.d2h_data;
          end
          else if (!is_term)
            left_next = left_reg - 8'h01;
          else
          begin
            re_next = 1'b1;
            res_next = (lnk.d2h_data == `FCL_TERM_ACK) ? `FCL_TRUE : `FCL_FALSE;
            state_next = fcl_pkg::HS_IDLE;
          end
        end
      default: state_next = fcl_pkg::HS_IDLE;
    endcase
    rdy_next = (state_next == fcl_pkg::HS_IDLE) && !(state_reg == fcl_pkg::HS_IDLE && cmd_valid);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= fcl_pkg::HS_IDLE;
      code_reg <= 8'h00;
      nargs_reg <= 2'h0;
      a0_reg <= 8'h00;
      a1_reg <= 8'h00;
      left_reg <= 8'h00;
      first_reg <= 1'b0;
      txv_reg <= 1'b0;
      txd_reg <= 8'h00;
      take_reg <= 1'b0;
      rdy_reg <= 1'b0;
      rv_reg <= 1'b0;
      rd_reg <= 8'h00;
      re_reg <= 1'b0;
      res_reg <= `FCL_FALSE;
    end
    else
    begin
      state_reg <= state_next;
      code_reg <= code_next;
      nargs_reg <= nargs_next;
      a0_reg <= a0_next;
      a1_reg <= a1_next;
      left_reg <= left_next;
      first_reg <= first_next;
      txv_reg <= txv_next;
      txd_reg <= txd_next;
      take_reg <= take_next;
      rdy_reg <= rdy_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      re_reg <= re_next;
      res_reg <= res_next;
    end
  end

  assign lnk.h2d_valid = txv_reg;
  assign lnk.h2d_data = txd_reg;
  assign lnk.d2h_ready = 1'b1;
  assign cmd_ready = rdy_reg;
  assign pay_take = take_reg;
  assign rsp_valid = rv_reg;
  assign rsp_data = rd_reg;
  assign rsp_end = re_reg;
  assign rsp_result = res_reg;
endmodule // fcl_host

// *** verif/fcl_assertions.sv ***
// checker of the byte channel between host and coprocessor
`include "fcl_map.svh"
module fcl_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_valid,
  input wire logic h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_valid,
  input wire logic d2h_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [1:0] idx_reg, idx_next;
  logic [7:0] code_reg, code_next, ofs_reg, ofs_next;
  logic h_tk, term_tk, fin_x;
  assign h_tk = h2d_valid && h2d_ready;
  assign term_tk = h_tk && h2d_data == `FCL_TERM_REQ;
  // args equal to the terminator byte would confuse this tracker
  assign fin_x = term_tk && (idx_reg == 2'h0 ||
    !(code_reg inside {8'h56, 8'h53, 8'h49, 8'h52, 8'h57}));
  always_comb
  begin
    idx_next = idx_reg;
    code_next = code_reg;
    ofs_next = ofs_reg;
    if (term_tk)
      idx_next = 2'h0;
    else if (h_tk)
    begin
      if (idx_reg != 2'h3)
        idx_next = idx_reg + 2'h1;
      if (idx_reg == 2'h0)
        code_next = h2d_data;
      if (idx_reg == 2'h1)
        ofs_next = h2d_data;
    end
    if (sys_rst)
      idx_next = 2'h0;
  end
  always_ff @(posedge clk)
  begin
    idx_reg <= idx_next;
    code_reg <= code_next;
    ofs_reg <= ofs_next;
  end
  property p_busy;
    term_tk |-> ##[1:2] !h2d_ready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("link still open after request end");
  property p_ready_term;
    h2d_ready && d2h_valid |-> d2h_data inside {`FCL_TERM_ACK, `FCL_TERM_NAK};
  endproperty
  a_ready_term: assert property (p_ready_term)
    else $error("request accepted during a reply");
  property p_ends;
    $fell(d2h_valid) |-> $past(d2h_data) inside {`FCL_TERM_ACK, `FCL_TERM_NAK};
  endproperty
  a_ends: assert property (p_ends)
    else $error("reply closed without terminator");
  property p_reply;
    term_tk |-> ##[2:300] (d2h_valid && d2h_data inside {`FCL_TERM_ACK, `FCL_TERM_NAK});
  endproperty
  a_reply: assert property (p_reply)
    else $error("no reply terminator in time");
  property p_nak;
    fin_x |-> ##[1:4] (d2h_valid && d2h_data == `FCL_TERM_NAK);
  endproperty
  a_nak: assert property (p_nak)
    else $error("unknown request not refused");
  property p_stat;
    term_tk && idx_reg == 2'h1 && code_reg == 8'h53 |->
      ##[1:4] (d2h_valid && d2h_data[7:2] == 6'h07 && d2h_data[1:0] != 2'h3);
  endproperty
  a_stat: assert property (p_stat)
    else $error("bad status byte");
  property p_id;
    term_tk && idx_reg == 2'h1 && code_reg == 8'h56 |->
      ##[1:4] (d2h_valid && d2h_data == `FCL_ID_B0);
  endproperty
  a_id: assert property (p_id)
    else $error("id request answered wrongly");
  property p_empty;
    term_tk && idx_reg == 2'h3 && code_reg == 8'h52 && ofs_reg == 8'hff |->
      ##[1:4] (d2h_valid && d2h_data == 8'h00) ##1 (d2h_valid && d2h_data == `FCL_TERM_NAK);
  endproperty
  a_empty: assert property (p_empty)
    else $error("invalid offset read not zero and refused");
endmodule // fcl_assertions

// *** verif/fieldbus_coproc_host_link_tb.sv ***
// testbench: host end and coprocessor end joined by the link
`include "fcl_map.svh"
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((e) !== (g)) \
    begin \
      err_count++; \
      $display("BAD %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module fieldbus_coproc_host_link_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic rdy; logic [7:0] code; logic [1:0] na; logic [7:0] a0; logic [7:0] a1;
    logic [7:0] f; int n; logic [7:0] res;
  } fcl_row_s;
  logic clk, sys_rst, engine_ready, ind_valid, ind_taken, init_pulse, eng_we;
  logic [7:0] ind_code, bps_sel, node_num, eng_addr, eng_wdata, eng_rdata;
  logic [1:0] dev_state, cmd_nargs;
  logic cmd_valid, cmd_ready, pay_valid, pay_take, rsp_valid, rsp_end;
  logic [7:0] cmd_code, cmd_arg0, cmd_arg1, pay_data, rsp_data, rsp_result;
  logic [7:0] pay_buf [4];
  logic [7:0] rx_q [$];
  logic [7:0] mon_q [$];
  int pay_idx, init_seen, err_count, checks_done, t;
  // row order matters: boot state first, then init, then the array
  fcl_row_s rows [14] = '{
    '{1'b0, 8'h49, 2'h2, 8'h01, 8'h01, 8'h21, 1, 8'h00},
    '{1'b0, 8'h53, 2'h0, 8'h00, 8'h00, 8'h1c, 2, 8'hff},
    '{1'b1, 8'h53, 2'h0, 8'h00, 8'h00, 8'h1d, 2, 8'hff},
    '{1'b1, 8'h56, 2'h0, 8'h00, 8'h00, 8'h5a, 5, 8'hff},
    '{1'b1, 8'h49, 2'h2, 8'h09, 8'h01, 8'h21, 1, 8'h00},
    '{1'b1, 8'h49, 2'h2, 8'h01, 8'h80, 8'h21, 1, 8'h00},
    '{1'b1, 8'h49, 2'h2, 8'h00, 8'h00, 8'h2e, 1, 8'hff},
    '{1'b1, 8'h49, 2'h2, 8'h08, 8'h7f, 8'h2e, 1, 8'hff},
    '{1'b1, 8'h53, 2'h0, 8'h00, 8'h00, 8'h1e, 2, 8'hff},
    '{1'b1, 8'h52, 2'h2, 8'hfe, 8'h05, 8'h01, 3, 8'hff},
    '{1'b1, 8'h52, 2'h2, 8'hff, 8'h01, 8'h00, 2, 8'h00},
    '{1'b1, 8'h52, 2'h2, 8'h10, 8'h00, 8'h00, 2, 8'h00},
    '{1'b1, 8'h58, 2'h0, 8'h00, 8'h00, 8'h21, 1, 8'h00},
    '{1'b1, 8'h52, 2'h2, 8'h00, 8'hff, 8'hff, 257, 8'hff}
  };
  fcl_if lnk ();
  fcl_dev fcl_dev_i (.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .engine_ready(engine_ready),
    .ind_valid(ind_valid), .ind_code(ind_code), .ind_taken(ind_taken),
    .init_pulse(init_pulse), .bps_sel(bps_sel), .node_num(node_num),
    .dev_state(dev_state), .eng_we(eng_we), .eng_addr(eng_addr),
    .eng_wdata(eng_wdata), .eng_rdata(eng_rdata));
  fcl_host fcl_host_i (.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_nargs(cmd_nargs), .cmd_arg0(cmd_arg0),
    .cmd_arg1(cmd_arg1), .cmd_ready(cmd_ready), .pay_valid(pay_valid),
    .pay_data(pay_data), .pay_take(pay_take), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_end(rsp_end), .rsp_result(rsp_result));
  fcl_assertions fcl_assertions_i (.clk(clk), .sys_rst(sys_rst),
    .h2d_data(lnk.h2d_data), .h2d_valid(lnk.h2d_valid), .h2d_ready(lnk.h2d_ready),
    .d2h_data(lnk.d2h_data), .d2h_valid(lnk.d2h_valid), .d2h_ready(lnk.d2h_ready));
  assign pay_data = pay_buf[pay_idx[1:0]];
  always @(negedge clk)
    if (pay_take === 1'b1)
      pay_idx++;
  always @(posedge clk)
  begin
    if (init_pulse === 1'b1)
      init_seen++;
    if (lnk.d2h_valid === 1'b1 && lnk.d2h_ready === 1'b1)
      mon_q.push_back(lnk.d2h_data);
  end
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // called at a falling edge; returns at the edge that shows the last byte
  task automatic req(input logic [7:0] c, input logic [1:0] na, input logic [7:0] a0,
    input logic [7:0] a1);
    int w;
    rx_q = {};
    w = 0;
    while (cmd_ready !== 1'b1 && w < 500)
    begin
      @(negedge clk);
      w++;
    end
    cmd_code = c;
    cmd_nargs = na;
    cmd_arg0 = a0;
    cmd_arg1 = a1;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    w = 0;
    while (rsp_end !== 1'b1 && w < 600)
    begin
      @(negedge clk);
      w++;
      if (rsp_valid === 1'b1)
        rx_q.push_back(rsp_data);
    end
    `CHK("reply end", 1'b1, rsp_end)
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
  initial
  begin
    sys_rst = 1'b1;
    {engine_ready, ind_valid, ind_code, eng_we, eng_addr, eng_wdata} = 27'h0;
    {cmd_valid, cmd_code, cmd_nargs, cmd_arg0, cmd_arg1, pay_valid} = 28'h0;
    pay_buf = '{8'h00, 8'h00, 8'h00, 8'h00};
    {pay_idx, init_seen, err_count, checks_done} = '0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    `CHK("state", 2'h0, dev_state)
    `CHK("result", 8'h00, rsp_result)
    `CHK("cmd ready", 1'b1, cmd_ready)
    $display("reset test done");
    foreach (rows[i])
    begin
      engine_ready = rows[i].rdy;
      req(rows[i].code, rows[i].na, rows[i].a0, rows[i].a1);
      `CHK("first", rows[i].f, rx_q[0])
      `CHK("length", rows[i].n, rx_q.size())
      `CHK("term", rows[i].res == 8'hff ? 8'h2e : 8'h21, rx_q[rx_q.size() - 1])
      `CHK("outcome", rows[i].res, rsp_result)
      $display("row %0d done", i);
    end
    `CHK("inits", 2, init_seen)
    `CHK("bps", 8'h08, bps_sel)
    `CHK("node", 8'h7f, node_num)
    pay_buf = '{8'h34, 8'h12, 8'h00, 8'h00};
    pay_idx = 0;
    pay_valid = 1'b1;
    req(8'h57, 2'h2, 8'h0a, 8'h02);
    pay_valid = 1'b0;
    `CHK("wr count", 8'h02, rx_q[0])
    req(8'h52, 2'h2, 8'h0a, 8'h02);
    `CHK("lo byte", 8'h34, rx_q[1])
    `CHK("hi byte", 8'h12, rx_q[2])
    eng_addr = 8'h0b;
    @(negedge clk);
    `CHK("engine view", 8'h12, eng_rdata)
    pay_buf = '{8'h99, 8'h88, 8'h77, 8'h00};
    pay_idx = 0;
    pay_valid = 1'b1;
    req(8'h57, 2'h2, 8'hfe, 8'h03);
    pay_valid = 1'b0;
    `CHK("end count", 8'h01, rx_q[0])
    `CHK("end term", 8'h2e, rx_q[1])
    {eng_we, eng_addr, eng_wdata} = 17'h120a5;
    @(negedge clk);
    eng_we = 1'b0;
    req(8'h52, 2'h2, 8'h20, 8'h01);
    `CHK("engine data", 8'ha5, rx_q[1])
    req(8'h52, 2'h2, 8'hfe, 8'h02);
    `CHK("last byte", 8'h99, rx_q[1])
    $display("array test done");
    mon_q = {};
    ind_code = 8'h42;
    ind_valid = 1'b1;
    t = 0;
    while (ind_taken !== 1'b1 && t < 50)
    begin
      @(negedge clk);
      t++;
    end
    `CHK("ind taken", 1'b1, ind_taken)
    ind_valid = 1'b0;
    repeat (6) @(negedge clk);
    `CHK("ind size", 2, mon_q.size())
    `CHK("ind code", 8'h42, mon_q[0])
    `CHK("ind end", 8'h2e, mon_q[1])
    $display("indication test done");
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("state again", 2'h0, dev_state)
    `CHK("bps again", 8'h00, bps_sel)
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    req(8'h53, 2'h0, 8'h00, 8'h00);
    `CHK("status again", 8'h1d, rx_q[0])
    $display("second reset test done");
    conclude();
  end
endmodule // fieldbus_coproc_host_link_tb
